// [rtl/qeic_top.sv]
// Purpose: quadrature encoder counter enable and position init control
// Assumes: inputs synchronous to CLK; CE low freezes every flip-flop
// Notes: CNT_W must not exceed the register width
//
// Chosen here: the register addresses and the plain strobed port.
`timescale 1ns/1ns

// Functional notes
// - enable bit set lets counters follow encoder
// - enable clear stops counters, registers stay accessible
// - stop-in-idle halts counting during device idle
// - bit 14 reads zero, ignores writes
// - mode 110 gives modulo position counting
// - mode 101 clears position at compare match
// - mode 100 loads on second index after home
// - mode 011 loads on first index after home
// - mode 010 loads on next index only
// - mode 001 clears position every index
// - mode 000 index leaves position alone
// - index match needs phase B at programmed level
// - index match needs phase A at programmed level
module qeic_top #(
  parameter int CNT_W = qeic_pkg::DATA_W
) (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic CE,
  input wire logic PHASE_A,
  input wire logic PHASE_B,
  input wire logic INDEX,
  input wire logic HOME,
  input wire logic IDLE,
  input wire logic [qeic_pkg::ADDR_W-1:0] ADDR,
  input wire logic [qeic_pkg::DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [qeic_pkg::DATA_W-1:0] RDATA,
  output logic RUNNING
);
  import qeic_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [DATA_W-1:0] ctrl;
    logic [CNT_W-1:0] init_val;
    logic [CNT_W-1:0] ge_cmp;
    logic [CNT_W-1:0] le_cmp;
    logic [CNT_W-1:0] pos;
    logic [CNT_W-1:0] idx_cnt;
    logic index_seen;
    logic home_seen;
    logic next_pend;
    logic run;
    logic [DATA_W-1:0] rdata;
  } qeic_top_state_type;

  qeic_top_state_type s_q;
  qeic_top_state_type s_d;

  logic step;
  logic up;
  logic index_evt;
  logic home_evt;
  logic home_load;
  logic home_armed;
  logic run;
  logic [2:0] mode;
  logic home_en;
  logic [DATA_W-1:0] status;
  logic [DATA_W-1:0] rd_mux;
  logic [CNT_W-1:0] wr_cnt;

  // ****************************************************************
  // encoder inputs
  // ****************************************************************
  qeic_decode u_decode (
    .clk(CLK),
    .reset(RESET),
    .ce(CE),
    .phase_a(PHASE_A),
    .phase_b(PHASE_B),
    .index(INDEX),
    .home(HOME),
    .match_a(s_q.ctrl[CTRL_MATCH_A_BIT]),
    .match_b(s_q.ctrl[CTRL_MATCH_B_BIT]),
    .step(step),
    .up(up),
    .index_evt(index_evt),
    .home_evt(home_evt)
  );

  qeic_home u_home (
    .clk(CLK),
    .reset(RESET),
    .ce(CE),
    .run(run),
    .enable(home_en),
    .second(mode == MODE_LOAD_SECOND),
    .home_evt(home_evt),
    .index_evt(index_evt),
    .load(home_load),
    .armed(home_armed)
  );

  // ****************************************************************
  // control decode
  // ****************************************************************
  always_comb begin
    mode = s_q.ctrl[CTRL_MODE_HI:CTRL_MODE_LO];
    // idle only halts the unit when software asked for it
    run = s_q.ctrl[CTRL_ENABLE_BIT] &
          ~(s_q.ctrl[CTRL_STOP_IDLE_BIT] & IDLE);
    home_en = (mode == MODE_LOAD_FIRST) | (mode == MODE_LOAD_SECOND);
    wr_cnt = WDATA[CNT_W-1:0];
  end

  // ****************************************************************
  // read mux
  // ****************************************************************
  always_comb begin
    status = REG_RESET;
    status[STAT_INDEX_SEEN_BIT] = s_q.index_seen;
    status[STAT_HOME_SEEN_BIT] = s_q.home_seen;
    status[STAT_NEXT_PEND_BIT] = s_q.next_pend;
    status[STAT_HOME_ARMED_BIT] = home_armed;
    status[STAT_RUN_BIT] = run;
    case (ADDR)
      ADDR_CONTROL: rd_mux = s_q.ctrl;
      ADDR_INIT_VALUE: rd_mux = DATA_W'(s_q.init_val);
      ADDR_GE_COMPARE: rd_mux = DATA_W'(s_q.ge_cmp);
      ADDR_LE_COMPARE: rd_mux = DATA_W'(s_q.le_cmp);
      ADDR_POSITION: rd_mux = DATA_W'(s_q.pos);
      ADDR_INDEX_COUNT: rd_mux = DATA_W'(s_q.idx_cnt);
      ADDR_STATUS: rd_mux = status;
      default: rd_mux = REG_RESET;
    endcase
  end

  // ****************************************************************
  // counters and registers
  // ****************************************************************
  always_comb begin
    s_d = s_q;
    s_d.run = run;
    // read data stand for exactly the cycle after the strobe
    s_d.rdata = RD ? rd_mux : REG_RESET;

    // counters hold while stopped; registers below stay writable
    if (run) begin
      if (index_evt) begin
        s_d.idx_cnt = s_q.idx_cnt + 1'b1;
      end
      if (mode == MODE_RESET_GE && s_q.pos == s_q.ge_cmp) begin
        s_d.pos = '0;
      end else if (index_evt && mode == MODE_RESET_EVERY) begin
        s_d.pos = '0;
      end else if (index_evt && mode == MODE_LOAD_NEXT &&
                   s_q.next_pend) begin
        s_d.pos = s_q.init_val;
        s_d.next_pend = 1'b0;
      end else if (home_load) begin
        s_d.pos = s_q.init_val;
      end else if (step) begin
        // modes 000 and 111 fall through here: index is ignored
        if (mode == MODE_MODULO) begin
          if (up) begin
            s_d.pos = (s_q.pos == s_q.ge_cmp) ? s_q.le_cmp
                                              : s_q.pos + 1'b1;
          end else begin
            s_d.pos = (s_q.pos == s_q.le_cmp) ? s_q.ge_cmp
                                              : s_q.pos - 1'b1;
          end
        end else if (up) begin
          s_d.pos = s_q.pos + 1'b1;
        end else begin
          s_d.pos = s_q.pos - 1'b1;
        end
      end
    end

    // sticky flags: clear by writing one, a same-cycle event wins
    if (WR && ADDR == ADDR_STATUS) begin
      s_d.index_seen = s_q.index_seen & ~WDATA[STAT_INDEX_SEEN_BIT];
      s_d.home_seen = s_q.home_seen & ~WDATA[STAT_HOME_SEEN_BIT];
    end
    if (index_evt) begin
      s_d.index_seen = 1'b1;
    end
    if (home_evt) begin
      s_d.home_seen = 1'b1;
    end

    // software writes take precedence over counting in the same cycle
    if (WR) begin
      case (ADDR)
        ADDR_CONTROL: begin
          s_d.ctrl = WDATA & CTRL_WRITE_MASK;
          // a write selecting next-index mode arms a single load
          s_d.next_pend = (WDATA[CTRL_MODE_HI:CTRL_MODE_LO] ==
                           MODE_LOAD_NEXT);
        end
        ADDR_INIT_VALUE: s_d.init_val = wr_cnt;
        ADDR_GE_COMPARE: s_d.ge_cmp = wr_cnt;
        ADDR_LE_COMPARE: s_d.le_cmp = wr_cnt;
        ADDR_POSITION: s_d.pos = wr_cnt;
        ADDR_INDEX_COUNT: s_d.idx_cnt = wr_cnt;
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      s_q <= '0;
    end else if (CE) begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  always_comb begin
    RDATA = s_q.rdata;
    RUNNING = s_q.run;
  end
endmodule : qeic_top

// [rtl/qeic_pkg.sv]
// Purpose: shared constants and types of the quadrature encoder control
// Assumes: 16-bit register port, word addressed
// Notes: register indices are the values placed on ADDR
package qeic_pkg;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 4;

  // ****************************************************************
  // register indices
  // ****************************************************************
  localparam logic [ADDR_W-1:0] ADDR_CONTROL = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_INIT_VALUE = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_GE_COMPARE = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_LE_COMPARE = 4'h3;
  localparam logic [ADDR_W-1:0] ADDR_POSITION = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_INDEX_COUNT = 4'h5;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h6;

  // ****************************************************************
  // encoder_control fields
  // ****************************************************************
  localparam int CTRL_ENABLE_BIT = 15;
  localparam int CTRL_STOP_IDLE_BIT = 13;
  localparam int CTRL_MODE_HI = 12;
  localparam int CTRL_MODE_LO = 10;
  localparam int CTRL_MATCH_B_BIT = 9;
  localparam int CTRL_MATCH_A_BIT = 8;
  localparam logic [DATA_W-1:0] CTRL_WRITE_MASK = 16'hBF00;
  localparam logic [DATA_W-1:0] CTRL_RESET = 16'h0000;

  // ****************************************************************
  // status fields
  // ****************************************************************
  localparam int STAT_INDEX_SEEN_BIT = 0;
  localparam int STAT_HOME_SEEN_BIT = 1;
  localparam int STAT_NEXT_PEND_BIT = 2;
  localparam int STAT_HOME_ARMED_BIT = 3;
  localparam int STAT_RUN_BIT = 4;

  // ****************************************************************
  // position init modes
  // ****************************************************************
  localparam logic [2:0] MODE_NO_EFFECT = 3'h0;
  localparam logic [2:0] MODE_RESET_EVERY = 3'h1;
  localparam logic [2:0] MODE_LOAD_NEXT = 3'h2;
  localparam logic [2:0] MODE_LOAD_FIRST = 3'h3;
  localparam logic [2:0] MODE_LOAD_SECOND = 3'h4;
  localparam logic [2:0] MODE_RESET_GE = 3'h5;
  localparam logic [2:0] MODE_MODULO = 3'h6;
  localparam logic [2:0] MODE_RESERVED = 3'h7;

  localparam logic [DATA_W-1:0] REG_RESET = 16'h0000;

  typedef enum logic [1:0] {
    HS_IDLE,
    HS_FIRST,
    HS_SECOND
  } qeic_home_state_type;
endpackage : qeic_pkg

// [rtl/qeic_decode.sv]
// Purpose: quadrature step decode and index and home edge detection
// Assumes: phase, index and home inputs are synchronous to clk
// Notes: step and event outputs are combinational from held history
`timescale 1ns/1ns
module qeic_decode (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic phase_a,
  input wire logic phase_b,
  input wire logic index,
  input wire logic home,
  input wire logic match_a,
  input wire logic match_b,
  output logic step,
  output logic up,
  output logic index_evt,
  output logic home_evt
);
  import qeic_pkg::*;

  typedef struct packed {
    logic a;
    logic b;
    logic qual;
    logic home;
  } qeic_dec_state_type;

  qeic_dec_state_type s_q;
  qeic_dec_state_type s_d;
  logic qual;

  always_comb begin
    qual = index & (phase_b == match_b) & (phase_a == match_a);
    // x4 decode: a step only when exactly one phase moved
    step = phase_a ^ s_q.a ^ phase_b ^ s_q.b;
    up = phase_a ^ s_q.b;
    index_evt = qual & ~s_q.qual;
    home_evt = home & ~s_q.home;
    s_d.a = phase_a;
    s_d.b = phase_b;
    s_d.qual = qual;
    s_d.home = home;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end
endmodule : qeic_decode

// [rtl/qeic_home.sv]
// Purpose: counts index events after a home event
// Assumes: events are one-cycle pulses
// Notes: a new home event restarts the count
`timescale 1ns/1ns
module qeic_home (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic run,
  input wire logic enable,
  input wire logic second,
  input wire logic home_evt,
  input wire logic index_evt,
  output logic load,
  output logic armed
);
  import qeic_pkg::*;

  typedef struct packed {
    qeic_home_state_type st;
  } qeic_home_reg_type;

  qeic_home_reg_type s_q;
  qeic_home_reg_type s_d;
  logic idx;

  always_comb begin
    s_d = s_q;
    // an index in the home cycle belongs before home, so it is ignored
    idx = run & enable & index_evt & ~home_evt;
    load = 1'b0;
    armed = (s_q.st != HS_IDLE);
    if (!enable) begin
      s_d.st = HS_IDLE;
    end else if (run && home_evt) begin
      s_d.st = HS_FIRST;
    end else begin
      case (s_q.st)
        HS_FIRST: begin
          if (idx) begin
            if (second) begin
              s_d.st = HS_SECOND;
            end else begin
              load = 1'b1;
              s_d.st = HS_IDLE;
            end
          end
        end
        HS_SECOND: begin
          if (idx) begin
            load = 1'b1;
            s_d.st = HS_IDLE;
          end
        end
        default: begin
          s_d.st = HS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_q.st <= HS_IDLE;
    end else if (ce) begin
      s_q <= s_d;
    end
  end
endmodule : qeic_home

// [test/qeic_monitor.sv]
// Purpose: port checker for the encoder control block
// Assumes: a shadow of the control word tracks accepted writes
// Notes: position effects are judged by the bench
`timescale 1ns/1ns
module qeic_monitor #(
  parameter int CNT_W = qeic_pkg::DATA_W
) (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic CE,
  input wire logic IDLE,
  input wire logic [qeic_pkg::ADDR_W-1:0] ADDR,
  input wire logic [qeic_pkg::DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [qeic_pkg::DATA_W-1:0] RDATA,
  input wire logic RUNNING
);
  import qeic_pkg::*;
  logic [DATA_W-1:0] ctrl_q;
  logic [DATA_W-1:0] ctrl_d;
  logic en;
  logic halt;
  logic go;
  always_comb begin
    ctrl_d = ctrl_q;
    if (CE && WR && ADDR == ADDR_CONTROL) begin
      ctrl_d = WDATA & CTRL_WRITE_MASK;
    end
  end
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      ctrl_q <= CTRL_RESET;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end
  assign en = ctrl_q[CTRL_ENABLE_BIT];
  assign halt = ctrl_q[CTRL_STOP_IDLE_BIT] && IDLE;
  assign go = en && !halt;
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  run_enable_a: assert property (
    $past(CE) && $past(go) |-> RUNNING)
    else $error("run missing while enabled");
  run_disable_a: assert property (
    $past(CE) && !$past(en) |-> !RUNNING)
    else $error("run while disabled");
  idle_halt_a: assert property (
    $past(CE) && $past(halt) |-> !RUNNING)
    else $error("run during idle halt");
  idle_keep_a: assert property (
    $past(CE) && $past(go) && $past(IDLE) |-> RUNNING)
    else $error("idle stopped a running block");
  ctrl_read_a: assert property (
    CE && RD && ADDR == ADDR_CONTROL |=> RDATA == $past(ctrl_q))
    else $error("control readback wrong");
  unmapped_zero_a: assert property (
    CE && RD && ADDR > ADDR_STATUS |=> RDATA == '0)
    else $error("unmapped read not zero");
  rdata_clear_a: assert property (
    CE && !RD |=> RDATA == '0)
    else $error("read data held too long");
  freeze_hold_a: assert property (
    !CE |=> $stable(RDATA) && $stable(RUNNING))
    else $error("outputs moved with clock enable low");
endmodule : qeic_monitor

bind qeic_top qeic_monitor #(.CNT_W(CNT_W)) mon (
  .CLK(CLK), .RESET(RESET), .CE(CE), .IDLE(IDLE),
  .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
  .RDATA(RDATA), .RUNNING(RUNNING)
);

// [test/qeic_enc_model.sv]
// Purpose: incremental encoder with index and home outputs
// Assumes: one request per two clocks at most
// Notes: gray sequence keeps one phase change per step
`timescale 1ns/1ns
module qeic_enc_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic step_req,
  input wire logic step_up,
  input wire logic index_req,
  input wire logic home_req,
  output logic phase_a,
  output logic phase_b,
  output logic index_out,
  output logic home_out
);
  logic [1:0] pos_q;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pos_q <= 2'h0;
      index_out <= 1'b0;
      home_out <= 1'b0;
    end else begin
      if (step_req) begin
        pos_q <= step_up ? pos_q + 2'h1 : pos_q - 2'h1;
      end
      index_out <= index_req;
      home_out <= home_req;
    end
  end
  // up order is 00, 10, 11, 01 on (a, b)
  assign phase_a = pos_q[1] ^ pos_q[0];
  assign phase_b = pos_q[1];
endmodule : qeic_enc_model

// [test/qeic_top_tb.sv]
// Purpose: self-checking bench for the encoder control block
// Assumes: 100 MHz clock, registers over the plain port
// Notes: expected positions follow from the stimulus alone
`timescale 1ns/1ns
module qeic_top_tb;
  import qeic_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic ce = 1'b1;
  logic idle = 1'b0;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic [DATA_W-1:0] rdata;
  logic running;
  logic step_req = 1'b0;
  logic step_up = 1'b1;
  logic index_req = 1'b0;
  logic home_req = 1'b0;
  logic pa;
  logic pb;
  logic index;
  logic home;
  int fail_count = 0;
  int num_checks = 0;
  always #5 clk = ~clk;
  qeic_top #(.CNT_W(16)) uut (
    .CLK(clk), .RESET(reset), .CE(ce), .PHASE_A(pa), .PHASE_B(pb),
    .INDEX(index), .HOME(home), .IDLE(idle), .ADDR(addr),
    .WDATA(wdata), .WR(wr_s), .RD(rd_s), .RDATA(rdata),
    .RUNNING(running)
  );
  qeic_enc_model encoder (
    .clk(clk), .reset(reset), .step_req(step_req), .step_up(step_up),
    .index_req(index_req), .home_req(home_req), .phase_a(pa),
    .phase_b(pb), .index_out(index), .home_out(home)
  );
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : wrap_up
  task automatic wreg(input logic [ADDR_W-1:0] a,
      input logic [DATA_W-1:0] d);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
    @(posedge clk);
  endtask : wreg
  task automatic rchk(input logic [ADDR_W-1:0] a,
      input logic [DATA_W-1:0] e);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    num_checks++;
    if (rdata !== e) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, rdata, e);
    end
    @(posedge clk);
  endtask : rchk
  task automatic pos(input logic [DATA_W-1:0] e);
    rchk(ADDR_POSITION, e);
  endtask : pos
  task automatic step(input int n, input logic up);
    repeat (n) begin
      step_req <= 1'b1;
      step_up <= up;
      @(posedge clk);
      step_req <= 1'b0;
      @(posedge clk);
    end
  endtask : step
  // settle time covers model, edge detect and position update
  task automatic pulse(input logic is_home);
    index_req <= !is_home;
    home_req <= is_home;
    @(posedge clk);
    index_req <= 1'b0;
    home_req <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : pulse
  // callers never pass the reserved mode
  function automatic logic [DATA_W-1:0] ctl(input logic [2:0] m,
      input logic [1:0] flip);
    return 16'h8000 | {3'h0, m, pb ^ flip[1], pa ^ flip[0], 8'h00};
  endfunction : ctl
  initial begin
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    rchk(ADDR_CONTROL, 16'h0000);
    wreg(ADDR_CONTROL, 16'hFB00);
    rchk(ADDR_CONTROL, 16'hBB00);
    rchk(4'hF, 16'h0000);
    // clock enable low must swallow the write
    ce <= 1'b0;
    wreg(ADDR_CONTROL, 16'h0000);
    ce <= 1'b1;
    rchk(ADDR_CONTROL, 16'hBB00);
    wreg(ADDR_CONTROL, 16'h0000);
    step(3, 1'b1);
    pos(16'h0000);
    wreg(ADDR_INIT_VALUE, 16'h1234);
    rchk(ADDR_INIT_VALUE, 16'h1234);
    wreg(ADDR_CONTROL, 16'h8000);
    step(3, 1'b1);
    step(1, 1'b0);
    pos(16'h0002);
    idle <= 1'b1;
    wreg(ADDR_CONTROL, 16'hA000);
    step(2, 1'b1);
    pos(16'h0002);
    wreg(ADDR_CONTROL, 16'h8000);
    step(2, 1'b1);
    pos(16'h0004);
    rchk(ADDR_STATUS, 16'h0010);
    idle <= 1'b0;
    wreg(ADDR_CONTROL, ctl(MODE_NO_EFFECT, 2'h0));
    pulse(1'b0);
    pos(16'h0004);
    wreg(ADDR_CONTROL, ctl(MODE_RESET_EVERY, 2'h2));
    pulse(1'b0);
    pos(16'h0004);
    wreg(ADDR_CONTROL, ctl(MODE_RESET_EVERY, 2'h1));
    pulse(1'b0);
    pos(16'h0004);
    wreg(ADDR_CONTROL, ctl(MODE_RESET_EVERY, 2'h0));
    pulse(1'b0);
    pos(16'h0000);
    wreg(ADDR_CONTROL, ctl(MODE_LOAD_NEXT, 2'h0));
    pulse(1'b0);
    pos(16'h1234);
    wreg(ADDR_POSITION, 16'h0005);
    pulse(1'b0);
    pos(16'h0005);
    wreg(ADDR_CONTROL, ctl(MODE_LOAD_FIRST, 2'h0));
    pulse(1'b1);
    pulse(1'b0);
    pos(16'h1234);
    wreg(ADDR_POSITION, 16'h0005);
    wreg(ADDR_CONTROL, ctl(MODE_LOAD_SECOND, 2'h0));
    pulse(1'b1);
    // both sticky flags set, home sequence armed, running
    rchk(ADDR_STATUS, 16'h001B);
    pulse(1'b0);
    pos(16'h0005);
    pulse(1'b0);
    pos(16'h1234);
    // seven matching index pulses so far, all while running
    rchk(ADDR_INDEX_COUNT, 16'h0007);
    wreg(ADDR_STATUS, 16'h0003);
    rchk(ADDR_STATUS, 16'h0010);
    wreg(ADDR_GE_COMPARE, 16'h0007);
    wreg(ADDR_LE_COMPARE, 16'h0002);
    rchk(ADDR_LE_COMPARE, 16'h0002);
    wreg(ADDR_CONTROL, ctl(MODE_RESET_GE, 2'h0));
    wreg(ADDR_POSITION, 16'h0005);
    step(1, 1'b1);
    pos(16'h0006);
    step(1, 1'b1);
    // the clear lands one cycle after the match
    repeat (2) @(posedge clk);
    pos(16'h0000);
    wreg(ADDR_CONTROL, ctl(MODE_MODULO, 2'h0));
    wreg(ADDR_POSITION, 16'h0007);
    step(1, 1'b1);
    pos(16'h0002);
    step(1, 1'b0);
    pos(16'h0007);
    // a reset in mid-run must clear position and control again
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    pos(16'h0000);
    rchk(ADDR_CONTROL, CTRL_RESET);
    wrap_up();
  end
  initial begin
    repeat (3000) @(posedge clk);
    fail_count++;
    wrap_up();
  end
endmodule : qeic_top_tb
